// ### rtl/adc_pkg.sv
// Shared constants and carrier types for the converter output interface
package adc_pkg;
  // Width of the parallel sample word
  localparam int CODE_W = 12;
  // Width of the quantiser input level from the front end
  localparam int ANALOG_W = 14;
  // Signed limits of the convertible range
  localparam int LEVEL_MAX = 2047;
  localparam int LEVEL_MIN = -2048;
  // Default pipeline latency in encode cycles
  localparam int PIPE_LATENCY = 5;
  // Depth of the output buffer
  localparam int BUF_DEPTH = 2;
  // Offset binary codes at the ends of the range
  localparam logic [CODE_W-1:0] CODE_FULL = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  // Toggling this bit maps offset binary to two's complement
  localparam logic [CODE_W-1:0] MSB_MASK = 12'h800;
  // Output reset values
  localparam logic [CODE_W-1:0] WORD_RESET = 12'h000;
  localparam logic LEVEL_RESET = 1'b0;

  // One conversion result: offset binary code plus range flag
  typedef struct packed {
    logic over;
    logic [CODE_W-1:0] code;
  } sample_s;
endpackage

// ### rtl/sample_buffer.sv
// Small valid/ready buffer between the pipeline and the output stage
`timescale 1ns/100ps
module sample_buffer #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Elaboration check: an empty or zero-width buffer cannot hold a word
  if (DEPTH < 1 || WIDTH < 1) begin : size_check
    $error("sample_buffer needs positive width and depth");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // Wrap an index at the buffer depth, which need not be a power of two
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Honest flags from the occupancy count
  assign in_ready_o = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg];

  // Storage written only on an accepted word
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      count_reg <= (PW+1)'(count_reg + push - pop);
    end
  end
endmodule

// ### rtl/adc_output_interface.sv
// Converter digital interface: encode sampling, pipeline, format and data-ready clock
`timescale 1ns/100ps
module adc_output_interface #(
  parameter int LATENCY = adc_pkg::PIPE_LATENCY,
  parameter int DEPTH = adc_pkg::BUF_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic encode_clock_in_i,
  input wire logic output_format_select_i,
  input wire logic signed [adc_pkg::ANALOG_W-1:0] analog_level_i,
  output logic data_ready_clock_o,
  output logic [adc_pkg::CODE_W-1:0] sample_word_o,
  output logic overrange_flag_o
);
  localparam int SW = $bits(adc_pkg::sample_s);

  // Elaboration checks: the pipeline needs a stage, the buffer two slots
  if (LATENCY < 1) begin : lat_check
    $error("LATENCY must be at least one encode cycle");
  end
  if (DEPTH < 2) begin : depth_check
    $error("DEPTH must hold at least two words");
  end

  // Synchronisers for the pin inputs
  logic enc_meta_reg;
  logic enc_sync_reg;
  logic enc_prev_reg;
  logic fmt_meta_reg;
  logic fmt_sync_reg;
  // Data-ready clock and its one-cycle history
  logic data_ready_reg;
  logic dr_prev_reg;
  // Pipeline stages
  adc_pkg::sample_s pipe_reg [LATENCY];
  logic [LATENCY-1:0] pipe_valid_reg;
  // Output registers
  logic [adc_pkg::CODE_W-1:0] word_reg;
  logic over_reg;
  // Edge events and buffer handshakes
  logic enc_rise;
  logic dr_fell;
  logic advance;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [SW-1:0] buf_out_data;
  adc_pkg::sample_s head;

  // Quantise a front-end level into an offset binary code with range flag
  function automatic adc_pkg::sample_s quantise(
    input logic signed [adc_pkg::ANALOG_W-1:0] lvl
  );
    adc_pkg::sample_s s;
    s.over = 1'b0;
    s.code = adc_pkg::CODE_W'(lvl) ^ adc_pkg::MSB_MASK;
    if (lvl > adc_pkg::LEVEL_MAX) begin
      s.over = 1'b1;
      s.code = adc_pkg::CODE_FULL;
    end else if (lvl < adc_pkg::LEVEL_MIN) begin
      s.over = 1'b1;
      s.code = adc_pkg::CODE_ZERO;
    end
    return s;
  endfunction

  // Apply the selected output format to an offset binary code
  function automatic logic [adc_pkg::CODE_W-1:0] apply_format(
    input logic [adc_pkg::CODE_W-1:0] code,
    input logic offset_bin
  );
    return offset_bin ? code : (code ^ adc_pkg::MSB_MASK);
  endfunction

  // Two-stage synchronisers; the encode pin is a plain sampled level here
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enc_meta_reg <= 1'b0;
      enc_sync_reg <= 1'b0;
      fmt_meta_reg <= 1'b0;
      fmt_sync_reg <= 1'b0;
    end else begin
      enc_meta_reg <= encode_clock_in_i;
      enc_sync_reg <= enc_meta_reg;
      fmt_meta_reg <= output_format_select_i;
      fmt_sync_reg <= fmt_meta_reg;
    end
  end

  // Edge history and the delayed copy driven out as the data-ready clock
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enc_prev_reg <= 1'b0;
      data_ready_reg <= 1'b0;
      dr_prev_reg <= 1'b0;
    end else begin
      enc_prev_reg <= enc_sync_reg;
      data_ready_reg <= enc_prev_reg;
      dr_prev_reg <= data_ready_reg;
    end
  end

  assign enc_rise = enc_sync_reg && !enc_prev_reg;
  assign dr_fell = dr_prev_reg && !data_ready_reg;
  assign data_ready_clock_o = data_ready_reg;

  // Pipeline steps once per encode rise; holds if the buffer cannot accept
  assign advance = enc_rise && (!pipe_valid_reg[LATENCY-1] || buf_in_ready);

  // Sample word pipeline, a fixed number of encode cycles deep
  always_ff @(posedge ref_clk_i) begin
    if (advance) begin
      pipe_reg[0] <= quantise(analog_level_i);
      for (int i = 1; i < LATENCY; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  // Stage valid bits fill after reset so no stale word is shown
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pipe_valid_reg <= '0;
    end else if (advance) begin
      pipe_valid_reg <= LATENCY'({pipe_valid_reg, 1'b1});
    end
  end

  // DEPTH-entry buffer, two by default, absorbs the gap between the encode rise and the fall
  sample_buffer #(
    .WIDTH(SW),
    .DEPTH(DEPTH)
  ) u_buffer (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(advance && pipe_valid_reg[LATENCY-1]),
    .in_ready_o(buf_in_ready),
    .in_data_i(pipe_reg[LATENCY-1]),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  // Drained only at a data-ready fall, one word per period
  assign buf_out_ready = dr_fell;
  assign head = adc_pkg::sample_s'(buf_out_data);

  // Output word and flag change only in the cycle after the fall
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_reg <= adc_pkg::WORD_RESET;
      over_reg <= adc_pkg::LEVEL_RESET;
    end else if (dr_fell && buf_out_valid) begin
      word_reg <= apply_format(head.code, fmt_sync_reg);
      over_reg <= head.over;
    end
  end

  assign sample_word_o = word_reg;
  assign overrange_flag_o = over_reg;

  // A word is loaded at one fall, followed by quiet cycles
  sequence s_load;
    dr_fell && buf_out_valid;
  endsequence

  sequence s_quiet;
    !dr_fell [*2];
  endsequence

  AST_FORMAT_SELECT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_load ##0 (fmt_sync_reg == 1'b0) |=> sample_word_o == ($past(head.code) ^ adc_pkg::MSB_MASK))
    else $error("two's complement word does not invert the top bit");

  AST_OFFSET_BINARY: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_load ##0 fmt_sync_reg |=> sample_word_o == $past(head.code))
    else $error("offset binary word differs from the converted code");

  AST_OVERRANGE_FLAG: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_load |=> overrange_flag_o == $past(head.over))
    else $error("overrange flag does not follow the converted sample");

  AST_DATA_READY_COPY: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(enc_sync_reg) |-> ##2 data_ready_clock_o)
    else $error("data-ready clock is not the delayed encode clock");

  // The low phase must follow as well, or a receiver sees a stretched period
  AST_DATA_READY_LOW: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $fell(enc_sync_reg) |-> ##2 !data_ready_clock_o)
    else $error("data-ready clock did not follow the encode fall");

  AST_CHANGE_AFTER_FALL: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ($changed(sample_word_o) || $changed(overrange_flag_o)) |-> !data_ready_clock_o && $past(dr_fell))
    else $error("output changed outside the cycle after a data-ready fall");

  AST_ONE_WORD_PER_PERIOD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    dr_fell |=> s_quiet)
    else $error("two loads within one data-ready period");

  AST_PIPE_LATENCY: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (advance && !pipe_valid_reg[0]) |=> pipe_valid_reg[0] && !pipe_valid_reg[LATENCY-1])
    else $error("pipeline produced a result before its latency elapsed");

  // A held pipeline would silently drop the sample of that encode rise
  AST_NO_STALL: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    enc_rise |-> advance)
    else $error("encode rise lost because the output buffer was full");
endmodule

// ### verification/adc_capture.sv
// Downstream capture register model fed by the converter outputs
`timescale 1ns/100ps
module adc_capture (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic data_ready_clock_i,
  input wire logic [adc_pkg::CODE_W-1:0] sample_word_i,
  input wire logic overrange_flag_i,
  output logic capture_o,
  output adc_pkg::sample_s captured_o
);
  logic ready_prev_reg;
  // Timing taken from data-ready rise only, never from encode
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_prev_reg <= 1'b0;
      capture_o <= 1'b0;
      captured_o <= '0;
    end else begin
      ready_prev_reg <= data_ready_clock_i;
      capture_o <= data_ready_clock_i && !ready_prev_reg;
      if (data_ready_clock_i && !ready_prev_reg) begin
        captured_o <= {overrange_flag_i, sample_word_i};
      end
    end
  end
endmodule

// ### verification/adc_output_interface_bench.sv
// Self-checking bench for the converter output interface
`timescale 1ns/100ps
module adc_output_interface_bench;
  localparam int LAT = 3;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic encode_clock_in = 1'b0;
  logic fmt = 1'b1;
  logic signed [adc_pkg::ANALOG_W-1:0] level = 14'sh0100;
  logic signed [adc_pkg::ANALOG_W-1:0] plan[$];
  logic dr, flag, cap;
  logic [adc_pkg::CODE_W-1:0] word;
  adc_pkg::sample_s cap_s;
  adc_pkg::sample_s got[$];
  int got_r[$];
  logic [3:0] hist = '0;
  logic dr_p1 = 1'b0;
  logic dr_p2 = 1'b0;
  adc_pkg::sample_s last = '0;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int rises = 0;
  int live = 0;
  int lv_tab[10] = '{0, 2047, 2048, -2048, -2049, 8191, -8192, 1, -1, 1365};

  adc_output_interface #(.LATENCY(LAT), .DEPTH(adc_pkg::BUF_DEPTH)) adc_output_interface_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .encode_clock_in_i(encode_clock_in),
    .output_format_select_i(fmt), .analog_level_i(level), .data_ready_clock_o(dr),
    .sample_word_o(word), .overrange_flag_o(flag));
  adc_capture adc_capture_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .data_ready_clock_i(dr), .sample_word_i(word), .overrange_flag_i(flag),
    .capture_o(cap), .captured_o(cap_s));

  always #25 ref_clk_i = ~ref_clk_i;
  // 2.5 Msps, even 200 ns phases, each edge 2 ns after a block clock rise
  initial begin
    #127;
    forever #200 encode_clock_in = ~encode_clock_in;
  end
  always @(posedge encode_clock_in) rises++;
  // New level well away from the encode rise that samples it
  always @(negedge encode_clock_in) begin
    @(posedge ref_clk_i);
    #2;
    if (plan.size() > 0) level = plan.pop_front();
  end

  task automatic check_bit(input logic act, input logic exp, input string what);
    checks++;
    if (act !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic check_sample(input adc_pkg::sample_s act, input adc_pkg::sample_s exp);
    checks++;
    if (act !== exp) begin
      err_count++;
      $display("MISMATCH %0t word %h expected %h", $time, act, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic adc_pkg::sample_s expect_of(input int lv, input logic ob);
    adc_pkg::sample_s s;
    s.over = (lv > adc_pkg::LEVEL_MAX) || (lv < adc_pkg::LEVEL_MIN);
    s.code = s.over ? (lv > 0 ? adc_pkg::CODE_FULL : adc_pkg::CODE_ZERO) : 12'(lv + 2048);
    if (!ob) s.code = s.code ^ adc_pkg::MSB_MASK;
    return s;
  endfunction

  // Timing monitor: delayed clock copy, update point, timeout
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      check_bit(1'b0, 1'b1, "timeout");
      finish_test();
    end
    live = nrst_i ? live + 1 : 0;
    if (live > 8) check_bit(dr, hist[3], "copy");
    if (live > 8 && {flag, word} !== last) check_bit(!dr_p1 && dr_p2, 1'b1, "update edge");
    hist <= {hist[2:0], encode_clock_in};
    dr_p1 <= dr;
    dr_p2 <= dr_p1;
    last <= {flag, word};
    if (cap) begin
      got.push_back(cap_s);
      got_r.push_back(rises);
    end
  end

  // Range sweep in one format, matched in order after the pipeline
  task automatic run_stream(input logic ob);
    int j;
    int r0;
    int r_pop;
    @(posedge ref_clk_i);
    #2;
    fmt = ob;
    repeat (80) @(posedge ref_clk_i);
    got.delete();
    got_r.delete();
    r0 = rises;
    foreach (lv_tab[i]) plan.push_back(14'(lv_tab[i]));
    // First level is applied at this fall and sampled at the next rise
    @(negedge encode_clock_in);
    r_pop = rises;
    repeat (8 * (20 + LAT)) @(posedge ref_clk_i);
    j = -1;
    foreach (got[i]) if (j < 0 && got[i] === expect_of(lv_tab[0], ob)) j = i;
    check_bit(j >= 0, 1'b1, "stream start");
    check_bit(j >= 0 && (got_r[j] - r_pop) == LAT + 2, 1'b1, "latency");
    for (int i = 0; i < 10 && j >= 0; i++) check_sample(got[j + i], expect_of(lv_tab[i], ob));
    check_bit(got.size() + 1 >= rises - r0 && got.size() <= rises - r0 + 1, 1'b1, "rate");
  endtask
  task automatic test_offset_binary();
    run_stream(1'b1);
    $display("test_offset_binary done");
  endtask
  task automatic test_twos_complement();
    run_stream(1'b0);
    $display("test_twos_complement done");
  endtask
  // Reset while words are in flight clears every output
  task automatic test_reset();
    @(posedge ref_clk_i);
    #2;
    nrst_i = 1'b0;
    @(posedge ref_clk_i);
    #2;
    check_bit(dr, 1'b0, "ready in reset");
    check_sample({flag, word}, {adc_pkg::LEVEL_RESET, adc_pkg::WORD_RESET});
    repeat (3) @(posedge ref_clk_i);
    #2;
    nrst_i = 1'b1;
    @(posedge ref_clk_i);
    #2;
    check_sample({flag, word}, {adc_pkg::LEVEL_RESET, adc_pkg::WORD_RESET});
    $display("test_reset done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_i);
    #2;
    nrst_i = 1'b1;
    test_offset_binary();
    test_reset();
    test_twos_complement();
    finish_test();
  end
endmodule
